// *** hw/aewc_defs.vh ***
// Constants for the automatic display-write command decoder.
// Included by the design files; holds definitions only.
`ifndef AEWC_DEFS_VH
`define AEWC_DEFS_VH

`define AEWC_CMD_WAVE4      8'h06
`define AEWC_CMD_WAVE5      8'h07
`define AEWC_WAVE4_ID       3'h4
`define AEWC_WAVE5_ID       3'h5
`define AEWC_SEG_BITS       256
`define AEWC_IDX_W          5
`define AEWC_LAST_IDX       5'h1F
`define AEWC_MODE_NORMAL    2'h0
`define AEWC_MODE_INVERT    2'h1
`define AEWC_MODE_ALL_WHITE 2'h2
`define AEWC_MODE_ALL_BLACK 2'h3
`define AEWC_SRC_PARAM      2'h0
`define AEWC_SRC_FLASH      2'h1
`define AEWC_SRC_TEMP       2'h2

`endif

// *** hw/aewc_wave_sel.v ***
// Drive waveform source selection for an automatic write.
// Assumes all inputs are stable registered levels on one clock.
`timescale 1ns/1ns
`include "aewc_defs.vh"

module aewc_wave_sel
(
    input  wire       flash_disable,
    input  wire       secondary_pin,
    input  wire       auto_temp_select_on,
    input  wire [2:0] fixed_wave,
    input  wire [2:0] temp_wave,
    output reg  [1:0] wave_source,
    output reg  [2:0] wave_id
);

    always @*
    begin
        if (flash_disable)
        begin
            wave_source = `AEWC_SRC_PARAM;
            wave_id     = 3'h0;
        end
        else if (secondary_pin || !auto_temp_select_on)
        begin
            wave_source = `AEWC_SRC_FLASH;
            wave_id     = fixed_wave;
        end
        else
        begin
            wave_source = `AEWC_SRC_TEMP;
            wave_id     = temp_wave;
        end
    end

endmodule

// *** hw/aewc_top.v ***
// Automatic display-write command decoder: command 0x06/0x07, segment data, update launch.
// Assumes the command interface delivers bytes on CLK with one-cycle strobes.
// Settings, range and standby are levels on CLK; only the chip-select pin is foreign.
`timescale 1ns/1ns
`include "aewc_defs.vh"

module aewc_top
(
    input  wire         CLK,
    input  wire         RSTN,
    input  wire         CMD_VALID,
    input  wire [7:0]   CMD_BYTE,
    input  wire         PARAM_VALID,
    input  wire [7:0]   PARAM_BYTE,
    input  wire         STANDBY,
    input  wire [4:0]   RANGE_START_INDEX,
    input  wire [4:0]   RANGE_END_INDEX,
    input  wire         FLASH_DISABLE,
    input  wire         SECONDARY_CHIP_SELECT_PIN,
    input  wire         AUTO_TEMP_SELECT_ON,
    input  wire [2:0]   TEMP_WAVE_ID,
    input  wire [1:0]   DISPLAY_POLARITY_MODE,
    output reg          UPDATE_START,
    output reg  [1:0]   WAVE_SOURCE,
    output reg  [2:0]   WAVE_ID,
    output reg          BUSY,
    output wire [255:0] NEXT_SEGMENT_BITS,
    output reg  [255:0] SEGMENT_BLACK
);

    //--------------------------------------------------
    // Reset release and pin synchronisers
    //--------------------------------------------------
    reg        rst_meta_reg;
    reg        rst_n_reg;
    reg        pin_meta_reg;
    reg        pin_sync_reg;

    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    always @(posedge CLK or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= SECONDARY_CHIP_SELECT_PIN;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    //--------------------------------------------------
    // Command capture and parameter loading
    //--------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_LOAD = 1'b1;

    reg  [255:0] next_segment_bits_reg;
    reg  [4:0]   param_idx_reg;
    reg          state_reg;
    reg          state_next;
    reg  [2:0]   fixed_wave_reg;
    wire [1:0]   sel_source;
    wire [2:0]   sel_wave;
    wire         is_wave4;
    wire         is_wave5;
    wire         is_write;
    wire         launch;
    wire         in_range;
    wire         last_param;

    assign is_wave4   = CMD_BYTE == `AEWC_CMD_WAVE4;
    assign is_wave5   = CMD_BYTE == `AEWC_CMD_WAVE5;
    assign is_write   = is_wave4 || is_wave5;
    assign in_range   = (param_idx_reg >= RANGE_START_INDEX) && (param_idx_reg <= RANGE_END_INDEX);
    assign last_param = param_idx_reg == RANGE_END_INDEX;
    assign launch     = PARAM_VALID && !CMD_VALID && (state_reg == ST_LOAD) &&
                        (last_param || (param_idx_reg == `AEWC_LAST_IDX));

    aewc_wave_sel u_wave_sel
    (
        .flash_disable       (FLASH_DISABLE),
        .secondary_pin       (pin_sync_reg),
        .auto_temp_select_on (AUTO_TEMP_SELECT_ON),
        .fixed_wave          (fixed_wave_reg),
        .temp_wave           (TEMP_WAVE_ID),
        .wave_source         (sel_source),
        .wave_id             (sel_wave)
    );

    //--------------------------------------------------
    // Write state: idle or loading parameters
    //--------------------------------------------------
    always @*
    begin
        case (state_reg)
            ST_IDLE:
            begin
                if (CMD_VALID && STANDBY && is_write)
                    state_next = ST_LOAD;
                else
                    state_next = ST_IDLE;
            end
            ST_LOAD:
            begin
                // Any command restarts or aborts the pending write
                if (CMD_VALID)
                    state_next = (STANDBY && is_write) ? ST_LOAD : ST_IDLE;
                else if (launch)
                    state_next = ST_IDLE;
                else
                    state_next = ST_LOAD;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLK or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            next_segment_bits_reg <= {256{1'b0}};
            param_idx_reg         <= 5'h00;
            state_reg             <= ST_IDLE;
            fixed_wave_reg        <= 3'h0;
            UPDATE_START          <= 1'b0;
            WAVE_SOURCE           <= 2'h0;
            WAVE_ID               <= 3'h0;
            BUSY                  <= 1'b0;
        end
        else
        begin
            UPDATE_START <= 1'b0;
            state_reg    <= state_next;
            BUSY         <= (state_next == ST_LOAD);
            if (CMD_VALID)
            begin
                // New command restarts the parameter index
                param_idx_reg <= RANGE_START_INDEX;
                fixed_wave_reg <= is_wave4 ? `AEWC_WAVE4_ID : `AEWC_WAVE5_ID;
            end
            else if (PARAM_VALID && (state_reg == ST_LOAD))
            begin
                if (in_range)
                begin
                    // Byte n fills bits 8n+7:8n, others untouched
                    next_segment_bits_reg[{param_idx_reg, 3'b000} +: 8] <= PARAM_BYTE;
                end
                if (launch)
                begin
                    UPDATE_START <= 1'b1;
                    WAVE_SOURCE  <= sel_source;
                    WAVE_ID      <= sel_wave;
                end
                else
                begin
                    param_idx_reg <= param_idx_reg + 5'h01;
                end
            end
        end
    end

    assign NEXT_SEGMENT_BITS = next_segment_bits_reg;

    //--------------------------------------------------
    // Segment colour per display mode
    //--------------------------------------------------
    always @(posedge CLK or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            SEGMENT_BLACK <= {256{1'b0}};
        end
        else
        begin
            case (DISPLAY_POLARITY_MODE)
                `AEWC_MODE_NORMAL:    SEGMENT_BLACK <= next_segment_bits_reg;
                `AEWC_MODE_INVERT:    SEGMENT_BLACK <= ~next_segment_bits_reg;
                `AEWC_MODE_ALL_WHITE: SEGMENT_BLACK <= {256{1'b0}};
                `AEWC_MODE_ALL_BLACK: SEGMENT_BLACK <= {256{1'b1}};
                default:              SEGMENT_BLACK <= {256{1'b0}};
            endcase
        end
    end

endmodule

// *** tb/aewc_props.sv ***
// Checker on the write decoder ports.
// Bound into aewc_top; assumes one clock and the active-low reset.
`timescale 1ns/1ns
module aewc_props
(
    input wire         CLK,
    input wire         RSTN,
    input wire         CMD_VALID,
    input wire [7:0]   CMD_BYTE,
    input wire         STANDBY,
    input wire         FLASH_DISABLE,
    input wire [2:0]   TEMP_WAVE_ID,
    input wire [1:0]   DISPLAY_POLARITY_MODE,
    input wire         UPDATE_START,
    input wire [1:0]   WAVE_SOURCE,
    input wire [2:0]   WAVE_ID,
    input wire         BUSY,
    input wire [255:0] NEXT_SEGMENT_BITS,
    input wire [255:0] SEGMENT_BLACK
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_wr_cmd;
        CMD_VALID && STANDBY && CMD_BYTE[7:1] == 7'h03;
    endsequence
    a_cmd_busy: assert property (s_wr_cmd |=> BUSY) else $error("no busy");
    a_refuse_idle: assert property (CMD_VALID && !STANDBY && !BUSY |=> !BUSY) else $error("busy");
    a_start_ends: assert property (UPDATE_START |-> !BUSY && $past(BUSY)) else $error("start");
    a_start_pulse: assert property (UPDATE_START |=> !UPDATE_START) else $error("pulse");
    a_param_wave: assert property (UPDATE_START && $past(FLASH_DISABLE) |-> WAVE_SOURCE == 2'h0)
        else $error("src");
    a_fixed_wave: assert property (UPDATE_START && WAVE_SOURCE == 2'h1 |-> WAVE_ID[2:1] == 2'h2)
        else $error("fix");
    a_temp_wave: assert property (UPDATE_START && WAVE_SOURCE == 2'h2 |-> WAVE_ID == $past(TEMP_WAVE_ID))
        else $error("temp");
    a_seg_data: assert property ($past(DISPLAY_POLARITY_MODE) < 2'h2 |-> SEGMENT_BLACK ==
        ($past(NEXT_SEGMENT_BITS) ^ {256{$past(DISPLAY_POLARITY_MODE) == 2'h1}})) else $error("seg");
    a_seg_fixed: assert property ($past(DISPLAY_POLARITY_MODE) > 2'h1 |-> SEGMENT_BLACK ==
        {256{$past(DISPLAY_POLARITY_MODE) == 2'h3}}) else $error("fill");
endmodule
bind aewc_top aewc_props u_props (.*);

// *** tb/aewc_host.sv ***
// Host model: one command byte, then its parameter bytes.
// Assumes the bench has set range and standby beforehand.
`timescale 1ns/1ns
module aewc_host
(
    input  wire       clk,
    output reg        cmd_valid,
    output reg  [7:0] cmd_byte,
    output reg        param_valid,
    output reg  [7:0] param_byte
);
    logic [7:0] sent[$];
    initial {cmd_valid, cmd_byte, param_valid, param_byte} = 18'h0;
    // Range and standby are set by the caller first
    task send(input logic [7:0] c, input int n, input int slow);
        sent.delete();
        cmd_byte = c;
        cmd_valid = 1'b1;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        cmd_byte = ~c;
        repeat (n)
        begin
            if (slow && sent.size() > 0)
            begin
                param_valid = 1'b0;
                param_byte = ~param_byte;
                @(posedge clk) #1;
            end
            param_byte = 8'($urandom);
            sent.push_back(param_byte);
            param_valid = 1'b1;
            @(posedge clk) #1;
        end
        param_valid = 1'b0;
        param_byte = ~param_byte;
    endtask
endmodule

// *** tb/test_auto_epd_write_cmd.sv ***
// Self-checking bench with a byte-level model of the segment data.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
module test_auto_epd_write_cmd;
    logic         CLK = 1'b0;
    logic         RSTN = 1'b0;
    logic         sby = 1'b1;
    logic [4:0]   rs = 5'h00;
    logic [4:0]   re = 5'h00;
    logic [2:0]   tw = 3'h3;
    logic [1:0]   md = 2'h0;
    logic [3:0]   cfg = 4'h0;
    logic [255:0] exp = 256'h0;
    wire          cv, pv, us, bsy;
    wire  [7:0]   cb, pb;
    wire  [1:0]   ws;
    wire  [2:0]   wid;
    wire  [255:0] nsb, sb;
    int           fails = 0, samples_checked = 0, t, s, e, i;
    aewc_top uut
    (
        .CLK(CLK), .RSTN(RSTN), .CMD_VALID(cv), .CMD_BYTE(cb), .PARAM_VALID(pv), .PARAM_BYTE(pb),
        .STANDBY(sby), .RANGE_START_INDEX(rs), .RANGE_END_INDEX(re), .FLASH_DISABLE(cfg[1]),
        .SECONDARY_CHIP_SELECT_PIN(cfg[2]), .AUTO_TEMP_SELECT_ON(cfg[3]), .TEMP_WAVE_ID(tw),
        .DISPLAY_POLARITY_MODE(md), .UPDATE_START(us), .WAVE_SOURCE(ws), .WAVE_ID(wid), .BUSY(bsy),
        .NEXT_SEGMENT_BITS(nsb), .SEGMENT_BLACK(sb)
    );
    aewc_host host (.clk(CLK), .cmd_valid(cv), .cmd_byte(cb), .param_valid(pv), .param_byte(pb));
    task chk(input string nm, input logic [255:0] seen, input logic [255:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always #4 CLK = ~CLK;
    initial
    begin
        #100000;
        fails++;
        results;
    end
    initial
    begin
        void'($urandom(32'h6D49890E));
        repeat (5) @(posedge CLK);
        #1 RSTN = 1'b1;
        repeat (3) @(posedge CLK);
        #1 sby = 1'b0;
        host.send(8'h06, 2, 0);
        chk("busy", bsy, 256'h0);
        chk("data", nsb, exp);
        sby = 1'b1;
        host.send(8'h07, 0, 0);
        chk("busy", bsy, 256'h1);
        @(posedge CLK);
        #1;
        host.send(8'h0C, 2, 0);
        chk("busy", bsy, 256'h0);
        chk("start", us, 256'h0);
        chk("data", nsb, exp);
        for (t = 0; t < 16; t++)
        begin
            cfg = 4'(t);
            md = 2'(t);
            tw = 3'($urandom);
            s = (t == 15) ? 0 : $urandom % 32;
            e = (t == 15) ? 31 : s + $urandom % (32 - s);
            rs = 5'(s);
            re = 5'(e);
            repeat (3) @(posedge CLK);
            #1;
            host.send(8'h06 | cfg[0], e - s + 1, $urandom % 2);
            for (i = 0; i < host.sent.size(); i++)
                exp[8 * (s + i) +: 8] = host.sent[i];
            chk("start", us, 256'h1);
            chk("data", nsb, exp);
            chk("src", ws, cfg[1] ? 0 : (cfg[2] | !cfg[3]) ? 1 : 2);
            chk("wave", wid, cfg[1] ? 0 : (cfg[2] | !cfg[3]) ? 4 + cfg[0] : tw);
            @(posedge CLK);
            #1;
            chk("black", sb, md[1] ? {256{md[0]}} : exp ^ {256{md[0]}});
            chk("start", us, 256'h0);
        end
        results;
    end
endmodule
